/* pkg/sar_seq_regs.svh */
// Purpose: Timing counts and field constants for the conversion sequencer
// Assumes: core_clk at 125 MHz (8 ns period)
// Notes:   Definitions only
`ifndef SAR_SEQ_REGS_SVH
`define SAR_SEQ_REGS_SVH

`define CLK_PERIOD_PS        32'd8000
`define RESULT_BITS          5'd16
`define STEP_LAST            4'hf
// Relaxed-timing minimum period at 1.5 MSPS, high-rate at 2 MSPS
`define PERIOD_RELAXED_PS    32'd666667
`define PERIOD_FAST_PS       32'd500000
`define PERIOD_RELAXED_CYC   ((`PERIOD_RELAXED_PS + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
`define PERIOD_FAST_CYC      ((`PERIOD_FAST_PS + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
// Idle limit in high-rate modes, 1 ms
`define IDLE_LIMIT_NS        32'd1000000
`define IDLE_LIMIT_CYC       (`IDLE_LIMIT_NS * 32'd1000 / `CLK_PERIOD_PS)
`define APERTURE_CYC         4'h2
`define SETTLE_CYC           4'h1

`endif

/* pkg/sar_seq_pkg.sv */
// Purpose: Types for the conversion sequencer
// Assumes: Nothing
// Notes:   Constants live in sar_seq_regs.svh
package sar_seq_pkg;

    typedef enum logic [2:0] {
        ST_ACQUIRE  = 3'b000,
        ST_APERTURE = 3'b001,
        ST_OPEN_GND = 3'b010,
        ST_TO_BOT   = 3'b011,
        ST_RESOLVE  = 3'b100,
        ST_FORM     = 3'b101
    } seq_state_e;

    typedef enum logic [1:0] {
        MODE_RELAXED  = 2'b00,
        MODE_FAST     = 2'b10,
        MODE_WIDEBAND = 2'b11
    } conv_mode_e;

    typedef struct packed {
        logic sampling_ground_switch_pos;
        logic sampling_ground_switch_neg;
        logic inputs_connected;
        logic conversion_voltage_bottom;
    } switch_ctl_s;

endpackage : sar_seq_pkg

/* design/sar_seq_sync.sv */
// Purpose: Three-stage pin synchroniser, change accepted when stages 2 and 3 agree
// Assumes: Single clock domain core_clk
// Notes:   Stage 1 feeds stage 2 only
`timescale 1ns/10ps
module sar_seq_sync #(
    parameter int          WIDTH = 1,
    parameter logic [31:0] INIT  = 32'h0000_0000
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    s1_reg[g]    <= INIT[g];
                    s2_reg[g]    <= INIT[g];
                    s3_reg[g]    <= INIT[g];
                    level_out[g] <= INIT[g];
                end else begin
                    s1_reg[g] <= pin_in[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    if (s2_reg[g] == s3_reg[g]) begin
                        level_out[g] <= s3_reg[g];
                    end
                end
            end
        end
    endgenerate
endmodule : sar_seq_sync

/* design/sar_conversion_sequencer.sv */
// Purpose: Acquisition / conversion sequencing of a 16-bit SAR converter
// Assumes: convert_start_n and mode pins come from outside the clock domain
// Notes:   Comparator is an input; code is registered, busy is decoded from state_reg
`timescale 1ns/10ps
`include "sar_seq_regs.svh"

// Behaviour
// - Convert only after acquisition and start low
// - Open ground switches, then tie arrays bottom
// - Sixteen halving steps, most significant first
// - Form code then drop busy
// - Both pins low: relaxed, 1.5 MSPS, no gap limit
// - High-rate modes allow 2 MSPS
// - High-rate accuracy only for gaps within 1 ms
// - Result belongs to its own sample
// - Hold instant fixed delay after start fall
module sar_conversion_sequencer
    import sar_seq_pkg::*;
#(
    parameter int unsigned IDLE_LIMIT = `IDLE_LIMIT_CYC,
    parameter int unsigned WIDTH      = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             convert_start_n,
    input  wire logic             high_rate_sel,
    input  wire logic             relaxed_sel_n,
    input  wire logic             comparator_high,
    output logic                  busy,
    output logic                  hold_sample,
    output switch_ctl_s           switches,
    output logic      [WIDTH-1:0] dac_code,
    output logic      [WIDTH-1:0] result_code,
    output logic                  stale_result,
    output conv_mode_e            mode
);
    localparam logic [31:0] RELAXED_CYC = `PERIOD_RELAXED_CYC;
    localparam logic [31:0] FAST_CYC    = `PERIOD_FAST_CYC;

    seq_state_e       state_reg;
    logic       [2:0] pins_sync;
    logic             start_prev_reg;
    logic             start_fall;
    logic       [3:0] wait_reg;
    logic       [3:0] step_reg;
    logic      [31:0] period_reg;
    logic      [31:0] idle_reg;
    logic             long_gap_reg;
    logic [WIDTH-1:0] trial_reg;

    sar_seq_sync #(
        .WIDTH (3),
        .INIT  (32'h0000_0001)
    ) u_sync (
        .core_clk  (core_clk),
        .rst       (rst),
        .pin_in    ({high_rate_sel, relaxed_sel_n, convert_start_n}),
        .level_out (pins_sync)
    );

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    function automatic conv_mode_e decode_mode(input logic hr, input logic rn);
        if (hr && rn) begin
            return MODE_WIDEBAND;
        end else if (hr) begin
            return MODE_FAST;
        end else begin
            return MODE_RELAXED;
        end
    endfunction : decode_mode

    assign mode       = decode_mode(pins_sync[2], pins_sync[1]);
    assign start_fall = start_prev_reg && !pins_sync[0];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            start_prev_reg <= 1'b1;
        end else begin
            start_prev_reg <= pins_sync[0];
        end
    end

    // ------------------------------------------------------------
    // Throughput pacing: acquisition lasts until the mode's period ends
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            period_reg <= 32'h0000_0000;
        end else if (state_reg == ST_ACQUIRE && start_fall && period_reg == 32'h0000_0000) begin
            // Fast modes pace at 2 MSPS, relaxed at 1.5 MSPS
            period_reg <= (mode == MODE_RELAXED) ? RELAXED_CYC - 32'd1 : FAST_CYC - 32'd1;
        end else if (period_reg != 32'h0000_0000) begin
            period_reg <= period_reg - 32'd1;
        end
    end

    // ------------------------------------------------------------
    // Idle gap watch, high-rate modes only
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idle_reg     <= 32'h0000_0000;
            long_gap_reg <= 1'b1;
        end else if (state_reg == ST_ACQUIRE) begin
            if (idle_reg < IDLE_LIMIT) begin
                idle_reg <= idle_reg + 32'd1;
            end else if (mode != MODE_RELAXED) begin
                long_gap_reg <= 1'b1;
            end
        end else if (state_reg == ST_FORM) begin
            idle_reg     <= 32'h0000_0000;
            long_gap_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_ACQUIRE;
            wait_reg  <= 4'h0;
            step_reg  <= 4'h0;
        end else begin
            case (state_reg)
                ST_ACQUIRE: begin
                    // Pacing period doubles as the acquisition-complete condition
                    if (start_fall && period_reg == 32'h0000_0000) begin
                        state_reg <= ST_APERTURE;
                        wait_reg  <= `APERTURE_CYC;
                    end
                end
                ST_APERTURE: begin
                    wait_reg <= wait_reg - 4'h1;
                    if (wait_reg == 4'h1) begin
                        state_reg <= ST_OPEN_GND;
                        wait_reg  <= `SETTLE_CYC;
                    end
                end
                ST_OPEN_GND: begin
                    wait_reg <= wait_reg - 4'h1;
                    if (wait_reg == 4'h1) begin
                        state_reg <= ST_TO_BOT;
                    end
                end
                ST_TO_BOT: begin
                    state_reg <= ST_RESOLVE;
                    step_reg  <= 4'h0;
                end
                ST_RESOLVE: begin
                    step_reg <= step_reg + 4'h1;
                    if (step_reg == `STEP_LAST) begin
                        state_reg <= ST_FORM;
                    end
                end
                ST_FORM: begin
                    state_reg <= ST_ACQUIRE;
                end
                default: begin
                    state_reg <= ST_ACQUIRE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Successive approximation register
    // ------------------------------------------------------------
    logic [WIDTH-1:0] bit_mask;
    assign bit_mask = {{(WIDTH-1){1'b0}}, 1'b1} << (WIDTH - 1 - 32'(step_reg));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trial_reg <= '0;
        end else if (state_reg == ST_TO_BOT) begin
            trial_reg <= {1'b1, {(WIDTH-1){1'b0}}};
        end else if (state_reg == ST_RESOLVE) begin
            // Keep or drop the bit under test, then try the next half weight
            trial_reg <= (comparator_high ? trial_reg : (trial_reg & ~bit_mask)) | (bit_mask >> 1);
        end
    end
    assign dac_code = trial_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            result_code  <= '0;
            stale_result <= 1'b1;
        end else if (state_reg == ST_FORM) begin
            result_code  <= trial_reg;
            stale_result <= long_gap_reg && mode != MODE_RELAXED;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign busy        = (state_reg != ST_ACQUIRE);
    assign hold_sample = (state_reg != ST_ACQUIRE && state_reg != ST_APERTURE);
    always_comb begin
        switches.sampling_ground_switch_pos = (state_reg == ST_ACQUIRE || state_reg == ST_APERTURE);
        switches.sampling_ground_switch_neg = switches.sampling_ground_switch_pos;
        switches.inputs_connected           = (state_reg == ST_ACQUIRE || state_reg == ST_APERTURE ||
                                               state_reg == ST_OPEN_GND);
        switches.conversion_voltage_bottom  = !switches.inputs_connected;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_start_needs_fall;
        @(posedge core_clk) disable iff (rst)
        $rose(busy) |-> $past(start_fall);
    endproperty
    a_start_needs_fall: assert property (p_start_needs_fall) else $error("busy rose without start fall");

    property p_gnd_before_bottom;
        @(posedge core_clk) disable iff (rst)
        $rose(switches.conversion_voltage_bottom) |->
            !switches.sampling_ground_switch_pos && !$past(switches.sampling_ground_switch_pos);
    endproperty
    a_gnd_before_bottom: assert property (p_gnd_before_bottom) else $error("arrays moved before ground opened");

    // Independent count of resolve cycles, so the check does not lean on step_reg
    logic [4:0] resolve_len_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            resolve_len_reg <= 5'h00;
        end else if (state_reg == ST_RESOLVE) begin
            resolve_len_reg <= resolve_len_reg + 5'h01;
        end else begin
            resolve_len_reg <= 5'h00;
        end
    end

    property p_sixteen_steps;
        @(posedge core_clk) disable iff (rst)
        (state_reg == ST_FORM) |-> resolve_len_reg == `RESULT_BITS;
    endproperty
    a_sixteen_steps: assert property (p_sixteen_steps) else $error("resolve not sixteen cycles");

    property p_msb_first;
        @(posedge core_clk) disable iff (rst)
        $rose(state_reg == ST_RESOLVE) |-> dac_code == {1'b1, {(WIDTH-1){1'b0}}};
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first trial not msb");

    property p_busy_drop_result;
        @(posedge core_clk) disable iff (rst)
        $fell(busy) |-> result_code == $past(trial_reg);
    endproperty
    a_busy_drop_result: assert property (p_busy_drop_result) else $error("result not from this conversion");

    property p_busy_span;
        @(posedge core_clk) disable iff (rst)
        $rose(busy) |-> busy [*8] ##1 busy [*8] ##1 busy [*5] ##1 !busy;
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("busy span wrong");

    property p_aperture;
        @(posedge core_clk) disable iff (rst)
        $rose(busy) |-> !hold_sample ##1 !hold_sample ##1 hold_sample;
    endproperty
    a_aperture: assert property (p_aperture) else $error("hold instant not fixed");

    property p_relaxed_no_stale;
        @(posedge core_clk) disable iff (rst)
        (state_reg == ST_FORM && mode == MODE_RELAXED) |=> !stale_result;
    endproperty
    a_relaxed_no_stale: assert property (p_relaxed_no_stale) else $error("relaxed mode flagged stale");

endmodule : sar_conversion_sequencer

/* verif/sar_host_model.sv */
// Purpose: Host pins and analog front end stand-in for the conversion sequencer
// Assumes: Callers change pins at the falling edge of core_clk
// Notes:   Input tracks until hold; the frozen value then feeds the comparator
`timescale 1ns/10ps
module sar_host_model
    import sar_seq_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        hold_sample,
    input  wire logic [15:0] dac_code,
    output logic             convert_start_n,
    output logic             high_rate_sel,
    output logic             relaxed_sel_n,
    output logic             comparator_high
);
    logic [15:0] analog_in;
    logic [15:0] held;

    initial begin
        convert_start_n = 1'h1;
        high_rate_sel   = 1'h0;
        relaxed_sel_n   = 1'h0;
        analog_in       = 16'h0000;
    end

    // Frozen once held, so an input swing during conversion does not change the code
    always @(negedge core_clk) begin
        if (!hold_sample) held <= analog_in;
    end

    assign comparator_high = (dac_code <= held);

    task automatic set_start(input logic v);
        convert_start_n = v;
    endtask : set_start

    task automatic set_mode(input conv_mode_e m);
        high_rate_sel = m[1];
        relaxed_sel_n = m[0];
    endtask : set_mode

    task automatic set_analog(input logic [15:0] v);
        analog_in = v;
    endtask : set_analog
endmodule : sar_host_model

/* verif/sar_conversion_sequencer_test.sv */
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Idle limit shortened to 200 cycles
// Notes:   Pins driven at the falling edge, outputs sampled there too
`timescale 1ns/10ps
module sar_conversion_sequencer_test
    import sar_seq_pkg::*;
;
    localparam int IDLE = 200;
    logic        core_clk;
    logic        rst;
    logic        convert_start_n;
    logic        high_rate_sel;
    logic        relaxed_sel_n;
    logic        comparator_high;
    logic        busy;
    logic        hold_sample;
    switch_ctl_s switches;
    logic [15:0] dac_code;
    logic [15:0] result_code;
    logic        stale_result;
    conv_mode_e  mode;
    int          err_total = 0;
    int          checks    = 0;

    sar_conversion_sequencer #(.IDLE_LIMIT(IDLE), .WIDTH(16)) i_dut (
        .core_clk(core_clk), .rst(rst), .convert_start_n(convert_start_n),
        .high_rate_sel(high_rate_sel), .relaxed_sel_n(relaxed_sel_n),
        .comparator_high(comparator_high), .busy(busy), .hold_sample(hold_sample),
        .switches(switches), .dac_code(dac_code), .result_code(result_code),
        .stale_result(stale_result), .mode(mode));

    sar_host_model i_host (
        .core_clk(core_clk), .hold_sample(hold_sample), .dac_code(dac_code),
        .convert_start_n(convert_start_n), .high_rate_sel(high_rate_sel),
        .relaxed_sel_n(relaxed_sel_n), .comparator_high(comparator_high));

    initial begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Shared checks
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // A missing handshake would hang the run, so every wait is bounded
    task automatic wait_level(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        if (busy !== lvl) begin
            $display("[ERR] busy wait expected %h seen %h", lvl, busy);
            err_total++;
            end_sim;
        end
    endtask : wait_level

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic conv(input logic [15:0] smp, input logic exp_stale);
        int n;
        i_host.set_analog(smp);
        @(negedge core_clk);
        i_host.set_start(1'h0);
        wait_level(1'h1);
        i_host.set_start(1'h1);
        chk("hold_early", 16'h0000, 16'(hold_sample));
        repeat (2) @(negedge core_clk);
        chk("hold", 16'h0001, 16'(hold_sample));
        chk("gnd_sw", 16'h0000, 16'({switches.sampling_ground_switch_pos, switches.sampling_ground_switch_neg}));
        chk("connected", 16'h0001, 16'(switches.inputs_connected));
        i_host.set_analog(~smp);
        @(negedge core_clk);
        chk("to_bottom", 16'h0001, 16'({switches.inputs_connected, switches.conversion_voltage_bottom}));
        @(negedge core_clk);
        chk("msb_trial", 16'h8000, dac_code);
        n = 5;
        while (busy === 1'h1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        chk("busy_cycles", 16'h0016, 16'(n));
        chk("result", smp, result_code);
        chk("stale", 16'(exp_stale), 16'(stale_result));
        $display("test conv %h done", smp);
    endtask : conv

    // Start falls about gap cycles after the previous take
    task automatic pace(input int gap, input logic exp_take);
        logic took;
        took = 1'h0;
        repeat (gap - 26) @(negedge core_clk);
        i_host.set_start(1'h0);
        repeat (12) begin
            @(negedge core_clk);
            if (busy === 1'h1) took = 1'h1;
        end
        i_host.set_start(1'h1);
        chk("taken", 16'(exp_take), 16'(took));
        wait_level(1'h0);
        repeat (30) @(negedge core_clk);
        $display("test pace %0d done", gap);
    endtask : pace

    task automatic test_modes;
        conv_mode_e tbl [3] = '{MODE_RELAXED, MODE_FAST, MODE_WIDEBAND};
        foreach (tbl[i]) begin
            i_host.set_mode(tbl[i]);
            repeat (5) @(negedge core_clk);
            chk("mode", 16'(tbl[i]), 16'(mode));
        end
        $display("test modes done");
    endtask : test_modes

    initial begin
        rst = 1'h1;
        repeat (16) @(negedge core_clk);
        chk("reset_busy", 16'h0000, 16'(busy));
        chk("reset_sw", 16'h000e, 16'(switches));
        rst = 1'h0;
        test_modes;
        i_host.set_mode(MODE_FAST);
        repeat (5) @(negedge core_clk);
        conv(16'h0000, 1'h1);
        pace(45, 1'h0);
        conv(16'hffff, 1'h0);
        pace(75, 1'h1);
        repeat (400) @(negedge core_clk);
        conv(16'h7fff, 1'h1);
        i_host.set_mode(MODE_RELAXED);
        repeat (400) @(negedge core_clk);
        conv(16'h8000, 1'h0);
        pace(75, 1'h0);
        conv(16'h1234, 1'h0);
        pace(95, 1'h1);
        i_host.set_mode(MODE_WIDEBAND);
        repeat (400) @(negedge core_clk);
        conv(16'ha5c3, 1'h1);
        end_sim;
    end
endmodule : sar_conversion_sequencer_test
